// ### uswp_pkg.sv
// Package for the serial transceiver write-protection register bank
package uswp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h20;
  localparam logic [7:0] OFS_RXTO = 8'h24;
  localparam logic [7:0] OFS_TXTG = 8'h28;
  localparam logic [7:0] OFS_PROT_MODE = 8'hE4;
  localparam logic [7:0] OFS_PROT_STAT = 8'hE8;
  localparam logic [7:0] OFS_MOD_REV = 8'hFC;

  // Unlock key and field layout of the protection mode register
  localparam logic [23:0] PROT_UNLOCK_KEY = 24'h55_5341;
  localparam int unsigned KEY_LSB = 8;
  localparam int unsigned KEY_MSB = 31;
  localparam int unsigned PROT_EN_BIT = 0;

  // Status register layout
  localparam int unsigned VFLAG_BIT = 0;
  localparam int unsigned VSRC_LSB = 8;
  localparam int unsigned VSRC_W = 16;

  // Guarded register widths
  localparam int unsigned RXTO_W = 17;
  localparam int unsigned TXTG_W = 8;
  localparam int unsigned BAUD_W = 19;

  // Fixed instance configuration
  localparam logic [4:0] RXTO_CNT_WIDTH = 5'h11;
  localparam logic [3:0] CLK_DIV_RATIO = 4'h8;
  localparam int unsigned DIV_CNT_W = 3;

  // Identification fields, values arbitrary
  localparam logic [11:0] MOD_REVISION = 12'h123;
  localparam logic [3:0] MOD_VARIANT = 4'h0;
  localparam int unsigned VARIANT_LSB = 16;

  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Bus request carrier
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
  } uswp_req_t;

  // Guarded configuration contents
  typedef struct packed {
    logic [DATA_W-1:0] mode;
    logic [BAUD_W-1:0] baud;
    logic [RXTO_W-1:0] rxto;
    logic [TXTG_W-1:0] txtg;
  } uswp_cfg_t;

endpackage : uswp_pkg

// ### uswp_clkdiv.sv
// Fixed divide-by-eight clock-enable generator
`timescale 1ns/1ps
`default_nettype none
module uswp_clkdiv
  import uswp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  output logic tick_o
);
  logic [DIV_CNT_W-1:0] cnt_q, cnt_d;

  // Free-running count modulo the ratio
  always_comb begin
    cnt_d = cnt_q + DIV_CNT_W'(1);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  // One pulse each wrap of the counter
  assign tick_o = ce_i && (cnt_q == DIV_CNT_W'(CLK_DIV_RATIO - 4'h1));
endmodule : uswp_clkdiv
`default_nettype wire

// ### uswp_rxto.sv
// Receiver time-out counter, 17 bits wide
`timescale 1ns/1ps
`default_nettype none
module uswp_rxto
  import uswp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [RXTO_W-1:0] value_i,
  input wire logic restart_i,
  input wire logic bit_tick_i,
  output logic expired_o
);
  logic [RXTO_W-1:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  // Load on restart, count down on bit ticks; zero value disables
  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (value_i == '0) begin
      cnt_d = '0;
      exp_d = 1'b0;
    end else if (restart_i) begin
      cnt_d = value_i;
      exp_d = 1'b0;
    end else if (bit_tick_i && cnt_q != '0) begin
      cnt_d = cnt_q - RXTO_W'(1);
      if (cnt_q == RXTO_W'(1)) begin
        exp_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;
endmodule : uswp_rxto
`default_nettype wire

// ### uswp_top.sv
// Write-protect, violation status and revision register bank
// Summary of operation
// - The enable bit changes only when the write carries the unlock key.
// - The key field always reads back as zero.
// - Enable one means protection on, zero means off.
// - Mode, baud, receiver time-out and timeguard are guarded.
// - A refused write records the target offset as violation source.
// - Status bit 0 is set by any violation since the last status read.
// - Reading the status register clears flag and source.
// - A read-only revision register holds revision and variant fields.
// - The receiver time-out counter and value are 17 bits wide.
// - The divided clock is the module clock divided by eight.
// - Time-out writes need protection off; zero disables time-out.
`timescale 1ns/1ps
`default_nettype none
module uswp_top
  import uswp_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic RX_RESTART_I,
  output logic RX_TIMEOUT_O,
  output logic DIV_TICK_O,
  output logic [DATA_W-1:0] CFG_MODE_O,
  output logic [BAUD_W-1:0] CFG_BAUD_O,
  output logic [RXTO_W-1:0] CFG_RXTO_O,
  output logic [TXTG_W-1:0] CFG_TXTG_O,
  output logic PROT_ENABLE_O
);
  uswp_req_t req;
  uswp_cfg_t cfg_q, cfg_d;
  logic prot_en_q, prot_en_d;
  logic vflag_q, vflag_d;
  logic [VSRC_W-1:0] vsrc_q, vsrc_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [DATA_W-1:0] bmask;
  logic guarded, take, wr_take, rd_take, refused;

  // Gather the bus request
  assign req.rd = AVS_READ_I;
  assign req.wr = AVS_WRITE_I;
  assign req.addr = AVS_ADDRESS_I;
  assign req.wdata = AVS_WRITEDATA_I;
  assign req.be = AVS_BYTEENABLE_I;

  // Byte-enable mask, one lane per generate step
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign bmask[gi*8 +: 8] = {8{req.be[gi]}};
    end
  endgenerate

  // One wait cycle then acknowledge
  assign take = CE_I && (req.rd || req.wr) && !ack_q;
  assign wr_take = take && req.wr;
  assign rd_take = take && req.rd && !req.wr;
  assign AVS_WAITREQUEST_O = !ack_q;
  assign AVS_READDATA_O = rdata_q;

  // Decode of the guarded set
  always_comb begin
    unique case (req.addr)
      OFS_MODE, OFS_BAUD, OFS_RXTO, OFS_TXTG: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  end
  assign refused = wr_take && guarded && prot_en_q;

  // Next state of registers and read data
  always_comb begin
    cfg_d = cfg_q;
    prot_en_d = prot_en_q;
    vflag_d = vflag_q;
    vsrc_d = vsrc_q;
    rdata_d = rdata_q;
    ack_d = take;
    if (wr_take && !refused) begin
      unique case (req.addr)
        OFS_MODE: begin
          cfg_d.mode = (cfg_q.mode & ~bmask) | (req.wdata & bmask);
        end
        OFS_BAUD: begin
          cfg_d.baud = BAUD_W'((DATA_W'(cfg_q.baud) & ~bmask)
                       | (req.wdata & bmask));
        end
        OFS_RXTO: begin
          cfg_d.rxto = RXTO_W'((DATA_W'(cfg_q.rxto) & ~bmask)
                       | (req.wdata & bmask));
        end
        OFS_TXTG: begin
          cfg_d.txtg = TXTG_W'((DATA_W'(cfg_q.txtg) & ~bmask)
                       | (req.wdata & bmask));
        end
        OFS_PROT_MODE: begin
          if (req.wdata[KEY_MSB:KEY_LSB] == PROT_UNLOCK_KEY && req.be[0]) begin
            prot_en_d = req.wdata[PROT_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_take) begin
      rdata_d = ZERO_WORD;
      unique case (req.addr)
        OFS_MODE: rdata_d = cfg_q.mode;
        OFS_BAUD: rdata_d = DATA_W'(cfg_q.baud);
        OFS_RXTO: rdata_d = DATA_W'(cfg_q.rxto);
        OFS_TXTG: rdata_d = DATA_W'(cfg_q.txtg);
        OFS_PROT_MODE: rdata_d[PROT_EN_BIT] = prot_en_q;
        OFS_PROT_STAT: begin
          rdata_d[VFLAG_BIT] = vflag_q;
          rdata_d[VSRC_LSB +: VSRC_W] = vsrc_q;
          vflag_d = 1'b0;
          vsrc_d = '0;
        end
        OFS_MOD_REV: begin
          rdata_d[0 +: $bits(MOD_REVISION)] = MOD_REVISION;
          rdata_d[VARIANT_LSB +: $bits(MOD_VARIANT)] = MOD_VARIANT;
        end
        default: rdata_d = ZERO_WORD;
      endcase
    end
    // Violation wins over a clearing read
    if (refused) begin
      vflag_d = 1'b1;
      vsrc_d = VSRC_W'(req.addr);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cfg_q <= '0;
      prot_en_q <= 1'b0;
      vflag_q <= 1'b0;
      vsrc_q <= '0;
      rdata_q <= ZERO_WORD;
      ack_q <= 1'b0;
    end else if (CE_I) begin
      cfg_q <= cfg_d;
      prot_en_q <= prot_en_d;
      vflag_q <= vflag_d;
      vsrc_q <= vsrc_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // Divided clock tick
  uswp_clkdiv u_div (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .tick_o(DIV_TICK_O)
  );

  // Receiver time-out counter
  uswp_rxto u_rxto (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .value_i(cfg_q.rxto),
    .restart_i(RX_RESTART_I),
    .bit_tick_i(DIV_TICK_O),
    .expired_o(RX_TIMEOUT_O)
  );

  // Configuration outputs
  assign CFG_MODE_O = cfg_q.mode;
  assign CFG_BAUD_O = cfg_q.baud;
  assign CFG_RXTO_O = cfg_q.rxto;
  assign CFG_TXTG_O = cfg_q.txtg;
  assign PROT_ENABLE_O = prot_en_q;
endmodule : uswp_top
`default_nettype wire

// ### uswp_monitor.sv
// Checker for the write-protect register bank ports
`timescale 1ns/1ps
`default_nettype none
module uswp_monitor
  import uswp_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [DATA_W-1:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic RX_TIMEOUT_O,
  input wire logic DIV_TICK_O,
  input wire logic [DATA_W-1:0] CFG_MODE_O,
  input wire logic [BAUD_W-1:0] CFG_BAUD_O,
  input wire logic [RXTO_W-1:0] CFG_RXTO_O,
  input wire logic [TXTG_W-1:0] CFG_TXTG_O,
  input wire logic PROT_ENABLE_O
);
  logic [3:0] gap_q;
  logic seen_q;
  logic rd_ack;
  logic key_wr;
  // Read acknowledge and keyed protection write
  assign rd_ack = AVS_READ_I && !AVS_WAITREQUEST_O;
  assign key_wr = AVS_WRITE_I && AVS_ADDRESS_I == OFS_PROT_MODE
    && AVS_WRITEDATA_I[31:8] == PROT_UNLOCK_KEY;
  // Enabled cycles since the last divider tick
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      gap_q <= 4'h0;
      seen_q <= 1'b0;
    end else if (CE_I) begin
      gap_q <= DIV_TICK_O ? 4'h0 : gap_q + 4'h1;
      seen_q <= seen_q | DIV_TICK_O;
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  AST_EN_KEY: assert property ($changed(PROT_ENABLE_O) |-> $past(key_wr))
    else $error("enable changed without key");
  AST_KEY_ZERO: assert property (rd_ack && AVS_ADDRESS_I == OFS_PROT_MODE
    |-> AVS_READDATA_O == {31'h0, PROT_ENABLE_O}) else $error("bad mode read");
  AST_GUARD: assert property ($past(PROT_ENABLE_O) |-> $stable(CFG_MODE_O)
    && $stable(CFG_BAUD_O) && $stable(CFG_RXTO_O) && $stable(CFG_TXTG_O))
    else $error("guarded register changed");
  AST_STAT: assert property (rd_ack && AVS_ADDRESS_I == OFS_PROT_STAT |->
    AVS_READDATA_O[31:24] == 8'h00 && AVS_READDATA_O[7:1] == 7'h00
    && (AVS_READDATA_O[0] || AVS_READDATA_O[23:8] == 16'h0000))
    else $error("bad status read");
  AST_VER: assert property (rd_ack && AVS_ADDRESS_I == OFS_MOD_REV |->
    AVS_READDATA_O == {12'h000, MOD_VARIANT, 4'h0, MOD_REVISION})
    else $error("bad revision read");
  AST_TICK_GAP: assert property (DIV_TICK_O && CE_I && seen_q |-> gap_q == 4'h7)
    else $error("tick spacing wrong");
  AST_TICK_MAX: assert property (gap_q < 4'h8)
    else $error("tick missing");
  AST_RXTO_OFF: assert property (CFG_RXTO_O == 0 ##1 CFG_RXTO_O == 0
    |-> !RX_TIMEOUT_O) else $error("time-out while disabled");
  cover property (rd_ack && AVS_READDATA_O[0]);
  cover property ($rose(PROT_ENABLE_O));
  cover property ($rose(RX_TIMEOUT_O));
endmodule : uswp_monitor
bind uswp_top uswp_monitor uswp_monitor_i (.*);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the write-protect register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin \
  checks++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, a); \
  end \
end
module tb_top
  import uswp_pkg::*;
();
  logic mclk, srst, ce, rd, wr, rrs, wq, tmo, tick, en;
  logic [7:0] adr;
  logic [3:0] be;
  logic [31:0] wd, rdata, mode, q, d, old;
  logic [18:0] baud;
  logic [16:0] rxto;
  logic [7:0] txtg;
  logic [7:0] nt;
  logic [7:0] ofs [4] = '{OFS_MODE, OFS_BAUD, OFS_RXTO, OFS_TXTG};
  int n_errors, checks, seed, n, p, k;
  uswp_top uswp_top_i (.MCLK_I(mclk), .SRST_I(srst), .CE_I(ce),
    .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wq), .RX_RESTART_I(rrs), .RX_TIMEOUT_O(tmo),
    .DIV_TICK_O(tick), .CFG_MODE_O(mode), .CFG_BAUD_O(baud),
    .CFG_RXTO_O(rxto), .CFG_TXTG_O(txtg), .PROT_ENABLE_O(en));
  // Clock of 5 ns
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic complete_run;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // One bus transfer, held until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] x);
    int m;
    m = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= x;
    do begin
      @(posedge mclk);
      m++;
    end while (wq !== 1'b0 && m < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0) begin
      n_errors++;
      complete_run();
    end
    @(posedge mclk);
  endtask : bus
  // Guarded register contents and writable width
  function automatic logic [31:0] cfg(int i);
    case (i)
      0: return mode;
      1: return {13'h0000, baud};
      2: return {15'h0000, rxto};
      default: return {24'h00_0000, txtg};
    endcase
  endfunction : cfg
  function automatic logic [31:0] msk(int i);
    case (i)
      0: return 32'hFFFF_FFFF;
      1: return 32'h0007_FFFF;
      2: return 32'h0001_FFFF;
      default: return 32'h0000_00FF;
    endcase
  endfunction : msk
  // Main sequence
  initial begin
    n_errors = 0;
    checks = 0;
    seed = 65762;
    srst = 1'b1;
    ce = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    rrs = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    be = 4'hF;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    bus(1'b0, OFS_MOD_REV, 32'h0000_0000);
    `CHK("rev", {12'h000, MOD_VARIANT, 4'h0, MOD_REVISION}, q)
    bus(1'b0, OFS_PROT_MODE, 32'h0000_0000);
    `CHK("mode0", 32'h0000_0000, q)
    for (p = 0; p < 2; p++) begin
      for (k = 0; k < 4; k++) begin
        old = cfg(k);
        d = $random(seed);
        bus(1'b1, ofs[k], d);
        `CHK("cfg", p ? old : d & msk(k), cfg(k))
        bus(1'b0, OFS_PROT_STAT, 32'h0000_0000);
        `CHK("stat", p ? {16'h0000, ofs[k], 8'h01} : 32'h0, q)
      end
      bus(1'b0, OFS_PROT_STAT, 32'h0000_0000);
      `CHK("clr", 32'h0000_0000, q)
      bus(1'b1, OFS_PROT_MODE, {PROT_UNLOCK_KEY ^ (d[23:0] | 24'h1), 8'h01});
      `CHK("badkey", p[0], en)
      bus(1'b1, OFS_PROT_MODE, {PROT_UNLOCK_KEY, 8'h01});
      bus(1'b0, OFS_PROT_MODE, 32'h0000_0000);
      `CHK("mode1", 32'h0000_0001, q)
    end
    bus(1'b1, OFS_PROT_MODE, {PROT_UNLOCK_KEY, 8'h00});
    `CHK("off", 1'b0, en)
    bus(1'b1, 8'h80, $random(seed));
    bus(1'b0, 8'h80, 32'h0000_0000);
    `CHK("unmap", 32'h0000_0000, q)
    bus(1'b1, OFS_RXTO, 32'h0000_0002);
    rrs <= 1'b1;
    @(posedge mclk);
    rrs <= 1'b0;
    n = 0;
    while (tmo !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    `CHK("tmo", 1'b1, tmo)
    bus(1'b1, OFS_RXTO, 32'h0000_0000);
    `CHK("tmo0", 1'b0, tmo)
    // Clock enable low freezes the divider, then eight ticks in 64 cycles
    ce <= 1'b0;
    nt = 8'h00;
    repeat (16) begin
      @(posedge mclk);
      nt = nt + {7'h00, tick};
    end
    `CHK("frz", 8'h00, nt)
    ce <= 1'b1;
    nt = 8'h00;
    repeat (64) begin
      @(posedge mclk);
      nt = nt + {7'h00, tick};
    end
    `CHK("ticks", 8'h08, nt)
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
